// ---- pkg/uifb_regs.svh ----
`ifndef UIFB_REGS_SVH
`define UIFB_REGS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define UIFB_OFF_IN_FLAGS   8'h00
`define UIFB_OFF_OUT_FLAGS  8'h04
`define UIFB_OFF_BUS_FLAGS  8'h08
`define UIFB_OFF_IN_MASK    8'h0c
`define UIFB_OFF_OUT_MASK   8'h10
`define UIFB_OFF_BUS_MASK   8'h14
`define UIFB_OFF_CTRL       8'h18
`define UIFB_OFF_STATUS     8'h1c

// ****************************************************************
// reset values
// ****************************************************************
`define UIFB_RST_FLAGS      4'h0
`define UIFB_RST_IN_MASK    4'hf
`define UIFB_RST_OUT_MASK   4'he
`define UIFB_RST_BUS_MASK   4'h6
`define UIFB_RST_CTRL       2'h0

// ****************************************************************
// field positions
// ****************************************************************
`define UIFB_BIT_SOF        3
`define UIFB_BIT_BUS_RESET  2
`define UIFB_BIT_WAKE       1
`define UIFB_BIT_SLEEP      0
`define UIFB_CTRL_SLEEP_EN  0
`define UIFB_CTRL_GIE       1
`define UIFB_STAT_SLEEP     0

// ****************************************************************
// bus answers and timing
// ****************************************************************
`define UIFB_RESP_OKAY      2'h0
`define UIFB_RESP_DECERR    2'h3
`define UIFB_FRAME_US       1000
`define UIFB_CLK_MHZ        200
`define UIFB_FRAME_CYCLES   (`UIFB_FRAME_US * `UIFB_CLK_MHZ)

`endif

// ---- pkg/uifb_pkg.sv ----
package uifb_pkg;

  // ****************************************************************
  // shared types
  // ****************************************************************
  typedef logic [3:0] uifb_flags_t;

  // read channel: one request at a time
  typedef enum logic [1:0] {
    UIFB_RD_IDLE = 2'b00,
    UIFB_RD_RESP = 2'b01
  } uifb_rd_state_t;

endpackage : uifb_pkg

// ---- src/uifb_frame_timer.sv ----
`timescale 1ns/100ps
// ****************************************************************
// frame timer: stands in for a lost start-of-frame token
// ****************************************************************
module uifb_frame_timer
  import uifb_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = 200000
) (
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_sof_token,
  input  wire logic i_stop,
  output logic      o_sof_synth
);

  localparam int unsigned CW = $clog2(FRAME_CYCLES + 1);

  logic [CW-1:0] count_reg;
  logic          armed_reg;
  logic          pulse_reg;
  wire  logic    expire;

  // expected frame boundary with no token seen since the last one
  assign expire = armed_reg & ~i_sof_token & (count_reg == CW'(FRAME_CYCLES - 1));

  // armed only after a real token, so no frames are invented before the host talks
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_reg <= '0;
      armed_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else if (i_stop) begin
      count_reg <= '0;
      armed_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      if (i_sof_token) begin
        armed_reg <= 1'b1;
      end
      count_reg <= (i_sof_token | expire) ? '0 : (armed_reg ? count_reg + CW'(1) : '0);
      pulse_reg <= expire;
    end
  end

  assign o_sof_synth = pulse_reg;

endmodule : uifb_frame_timer

// ---- src/uifb_top.sv ----
`timescale 1ns/100ps
`include "uifb_regs.svh"
// Overview of operation
// - control endpoint flag at bit 0, IN endpoints 1-3 at bits 1-3.
// - reading the IN flag register returns flags then clears them all.
// - OUT endpoints 1-3 pending flags sit at bits 1-3.
// - reading the OUT flag register returns flags then clears them all.
// - bits 7:4 of every flag register read zero, writes ignored.
// - bit 0 of the OUT flag register reads zero, writes ignored.
// - a start-of-frame token sets the frame-start flag, bit 3.
// - a missed frame token is synthesized, so the flag sets once per frame.
// - bus reset signaling sets bit 2 of the bus event register.
// - resume signaling sets bit 1 only while in suspend mode.
// - suspend signaling sets bit 0 only while sleep detection is enabled.
// - reading the bus event register returns flags then clears all four.
// - interrupt requested while any unmasked flag is set, gated by global enable.
// - reading bus events after a detected resume leaves suspend mode.
module uifb_top
  import uifb_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = `UIFB_FRAME_CYCLES
) (
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RESET_N,
  input  wire logic [7:0]  I_AXI_AWADDR,
  input  wire logic        I_AXI_AWVALID,
  output logic             O_AXI_AWREADY,
  input  wire logic [31:0] I_AXI_WDATA,
  input  wire logic [3:0]  I_AXI_WSTRB,
  input  wire logic        I_AXI_WVALID,
  output logic             O_AXI_WREADY,
  output logic [1:0]       O_AXI_BRESP,
  output logic             O_AXI_BVALID,
  input  wire logic        I_AXI_BREADY,
  input  wire logic [7:0]  I_AXI_ARADDR,
  input  wire logic        I_AXI_ARVALID,
  output logic             O_AXI_ARREADY,
  output logic [31:0]      O_AXI_RDATA,
  output logic [1:0]       O_AXI_RRESP,
  output logic             O_AXI_RVALID,
  input  wire logic        I_AXI_RREADY,
  input  wire logic [3:0]  I_IN_EP_EVENT,
  input  wire logic [3:1]  I_OUT_EP_EVENT,
  input  wire logic        I_SOF_TOKEN,
  input  wire logic        I_BUS_RESET_DET,
  input  wire logic        I_RESUME_DET,
  input  wire logic        I_SUSPEND_DET,
  output logic             O_IRQ,
  output logic             O_SLEEP_STATE
);

  // ****************************************************************
  // state
  // ****************************************************************
  uifb_flags_t    in_flag_reg;
  uifb_flags_t    out_flag_reg;
  uifb_flags_t    bus_flag_reg;
  uifb_flags_t    in_mask_reg;
  uifb_flags_t    out_mask_reg;
  uifb_flags_t    bus_mask_reg;
  logic [1:0]     ctrl_reg;
  logic           sleep_state_reg;
  logic           wake_seen_reg;
  logic           irq_reg;
  logic           aw_have_reg;
  logic [7:0]     aw_addr_reg;
  logic           w_have_reg;
  logic [3:0]     w_data_reg;
  logic           w_strb0_reg;
  logic           awready_reg;
  logic           wready_reg;
  logic           bvalid_reg;
  logic [1:0]     bresp_reg;
  uifb_rd_state_t rd_state_reg;
  uifb_rd_state_t rd_state_next;
  logic           arready_reg;
  logic           rvalid_reg;
  logic [31:0]    rdata_reg;
  logic [1:0]     rresp_reg;
  wire  logic     sof_synth;

  // ****************************************************************
  // event sources
  // ****************************************************************
  wire logic        sof_set   = I_SOF_TOKEN | sof_synth;
  wire logic        wake_set  = I_RESUME_DET & sleep_state_reg;
  wire logic        sleep_set = I_SUSPEND_DET & ctrl_reg[`UIFB_CTRL_SLEEP_EN];
  wire uifb_flags_t in_set    = I_IN_EP_EVENT;
  wire uifb_flags_t out_set   = {I_OUT_EP_EVENT, 1'b0};
  wire uifb_flags_t bus_set   = {sof_set, I_BUS_RESET_DET, wake_set, sleep_set};

  // the timer restarts on every real token and idles through reset or suspend
  uifb_frame_timer #(
    .FRAME_CYCLES (FRAME_CYCLES)
  ) u_frame_timer (
    .i_clk       (I_REF_CLK),
    .i_reset_n   (I_RESET_N),
    .i_sof_token (I_SOF_TOKEN),
    .i_stop      (I_BUS_RESET_DET | sleep_state_reg),
    .o_sof_synth (sof_synth)
  );

  // ****************************************************************
  // read decode
  // ****************************************************************
  wire logic ar_fire    = I_AXI_ARVALID & O_AXI_ARREADY;
  // word index kept at the width of the offset constants it is compared with
  wire logic [7:0] ar_w = {2'b00, I_AXI_ARADDR[7:2]};
  wire logic rd_in      = (ar_w == `UIFB_OFF_IN_FLAGS >> 2);
  wire logic rd_out     = (ar_w == `UIFB_OFF_OUT_FLAGS >> 2);
  wire logic rd_bus     = (ar_w == `UIFB_OFF_BUS_FLAGS >> 2);
  wire logic rd_in_m    = (ar_w == `UIFB_OFF_IN_MASK >> 2);
  wire logic rd_out_m   = (ar_w == `UIFB_OFF_OUT_MASK >> 2);
  wire logic rd_bus_m   = (ar_w == `UIFB_OFF_BUS_MASK >> 2);
  wire logic rd_ctrl    = (ar_w == `UIFB_OFF_CTRL >> 2);
  wire logic rd_stat    = (ar_w == `UIFB_OFF_STATUS >> 2);
  wire logic rd_hit     = rd_in | rd_out | rd_bus | rd_in_m | rd_out_m | rd_bus_m | rd_ctrl | rd_stat;
  wire logic clr_in     = ar_fire & rd_in;
  wire logic clr_out    = ar_fire & rd_out;
  wire logic clr_bus    = ar_fire & rd_bus;

  // narrow registers sit in the low bits; everything above reads zero
  wire logic [3:0] rd_low =
    ({4{rd_in}}    & in_flag_reg)  |
    ({4{rd_out}}   & out_flag_reg) |
    ({4{rd_bus}}   & bus_flag_reg) |
    ({4{rd_in_m}}  & in_mask_reg)  |
    ({4{rd_out_m}} & out_mask_reg) |
    ({4{rd_bus_m}} & bus_mask_reg) |
    ({4{rd_ctrl}}  & {2'h0, ctrl_reg}) |
    ({4{rd_stat}}  & {3'h0, sleep_state_reg});
  wire logic [31:0] rd_mux = {28'h0, rd_low};

  // ****************************************************************
  // write decode
  // ****************************************************************
  wire logic aw_fire    = I_AXI_AWVALID & awready_reg;
  wire logic w_fire     = I_AXI_WVALID & wready_reg;
  wire logic wr_do      = aw_have_reg & w_have_reg & ~bvalid_reg;
  wire logic aw_hnext   = (aw_have_reg | aw_fire) & ~wr_do;
  wire logic w_hnext    = (w_have_reg | w_fire) & ~wr_do;
  wire logic [7:0] aw_w = {2'b00, aw_addr_reg[7:2]};
  wire logic wr_hit     =
    (aw_w == `UIFB_OFF_IN_FLAGS >> 2) | (aw_w == `UIFB_OFF_OUT_FLAGS >> 2) |
    (aw_w == `UIFB_OFF_BUS_FLAGS >> 2) | (aw_w == `UIFB_OFF_IN_MASK >> 2) |
    (aw_w == `UIFB_OFF_OUT_MASK >> 2) | (aw_w == `UIFB_OFF_BUS_MASK >> 2) |
    (aw_w == `UIFB_OFF_CTRL >> 2) | (aw_w == `UIFB_OFF_STATUS >> 2);
  wire logic wr_en      = wr_do & w_strb0_reg;
  wire logic wr_in_m    = wr_en & (aw_w == `UIFB_OFF_IN_MASK >> 2);
  wire logic wr_out_m   = wr_en & (aw_w == `UIFB_OFF_OUT_MASK >> 2);
  wire logic wr_bus_m   = wr_en & (aw_w == `UIFB_OFF_BUS_MASK >> 2);
  wire logic wr_ctrl    = wr_en & (aw_w == `UIFB_OFF_CTRL >> 2);

  // ****************************************************************
  // pending flags
  // ****************************************************************
  // the flag banks have no write path at all, so writes cannot reach them
  // set is or-ed after the clear so an event in the read cycle survives
  for (genvar b = 0; b < 4; b++) begin : g_flag
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
        in_flag_reg[b]  <= 1'b0;
        out_flag_reg[b] <= 1'b0;
        bus_flag_reg[b] <= 1'b0;
      end else begin
        in_flag_reg[b]  <= (in_flag_reg[b] & ~clr_in) | in_set[b];
        out_flag_reg[b] <= (out_flag_reg[b] & ~clr_out) | out_set[b];
        bus_flag_reg[b] <= (bus_flag_reg[b] & ~clr_bus) | bus_set[b];
      end
    end
  end

  // ****************************************************************
  // masks, control, suspend tracking, interrupt
  // ****************************************************************
  wire logic any_pend = |((in_flag_reg & in_mask_reg) | (out_flag_reg & out_mask_reg) |
                          (bus_flag_reg & bus_mask_reg));

  // suspend entry is taken from an enabled suspend detection
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      in_mask_reg     <= `UIFB_RST_IN_MASK;
      out_mask_reg    <= `UIFB_RST_OUT_MASK;
      bus_mask_reg    <= `UIFB_RST_BUS_MASK;
      ctrl_reg        <= `UIFB_RST_CTRL;
      sleep_state_reg <= 1'b0;
      wake_seen_reg   <= 1'b0;
      irq_reg         <= 1'b0;
    end else begin
      if (wr_in_m) in_mask_reg <= w_data_reg;
      if (wr_out_m) out_mask_reg <= {w_data_reg[3:1], 1'b0};
      if (wr_bus_m) bus_mask_reg <= w_data_reg;
      if (wr_ctrl) ctrl_reg <= w_data_reg[1:0];
      sleep_state_reg <= sleep_set | (sleep_state_reg & ~(clr_bus & wake_seen_reg));
      wake_seen_reg   <= wake_set | (wake_seen_reg & ~clr_bus);
      irq_reg         <= ctrl_reg[`UIFB_CTRL_GIE] & any_pend;
    end
  end

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  // address and data are caught in either order; a second pair waits out bvalid
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_have_reg  <= 1'b0;
      w_data_reg  <= 4'h0;
      w_strb0_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `UIFB_RESP_OKAY;
    end else begin
      if (aw_fire) aw_addr_reg <= I_AXI_AWADDR;
      if (w_fire) begin
        w_data_reg  <= I_AXI_WDATA[3:0];
        w_strb0_reg <= I_AXI_WSTRB[0];
      end
      aw_have_reg <= aw_hnext;
      w_have_reg  <= w_hnext;
      awready_reg <= ~aw_hnext;
      wready_reg  <= ~w_hnext;
      if (wr_do) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? `UIFB_RESP_OKAY : `UIFB_RESP_DECERR;
      end else if (I_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  always_comb begin
    rd_state_next = rd_state_reg;
    unique case (rd_state_reg)
      UIFB_RD_IDLE: if (ar_fire) rd_state_next = UIFB_RD_RESP;
      UIFB_RD_RESP: if (I_AXI_RREADY) rd_state_next = UIFB_RD_IDLE;
      default:      rd_state_next = UIFB_RD_IDLE;
    endcase
  end

  // data is captured at the accepting edge, the same edge that clears the bank
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rd_state_reg <= UIFB_RD_IDLE;
      arready_reg  <= 1'b0;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= 32'h0;
      rresp_reg    <= `UIFB_RESP_OKAY;
    end else begin
      rd_state_reg <= rd_state_next;
      // handshake outputs follow the next state so they leave a flip-flop directly
      arready_reg  <= (rd_state_next == UIFB_RD_IDLE);
      rvalid_reg   <= (rd_state_next == UIFB_RD_RESP);
      if (ar_fire) begin
        rdata_reg <= rd_mux;
        rresp_reg <= rd_hit ? `UIFB_RESP_OKAY : `UIFB_RESP_DECERR;
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign O_AXI_AWREADY = awready_reg;
  assign O_AXI_WREADY  = wready_reg;
  assign O_AXI_BVALID  = bvalid_reg;
  assign O_AXI_BRESP   = bresp_reg;
  assign O_AXI_ARREADY = arready_reg;
  assign O_AXI_RVALID  = rvalid_reg;
  assign O_AXI_RDATA   = rdata_reg;
  assign O_AXI_RRESP   = rresp_reg;
  assign O_IRQ         = irq_reg;
  assign O_SLEEP_STATE = sleep_state_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);

  AST_IN_MAP: assert property (ar_fire && rd_in |=> O_AXI_RDATA[3:0] == $past(in_flag_reg))
    else $error("in flag read data wrong");
  AST_IN_CLEAR: assert property (clr_in && in_set == 4'h0 |=> in_flag_reg == 4'h0)
    else $error("in flags not cleared by read");
  AST_OUT_MAP: assert property (ar_fire && rd_out |=> O_AXI_RDATA[3:0] == $past(out_flag_reg))
    else $error("out flag read data wrong");
  AST_OUT_CLEAR: assert property (clr_out && I_OUT_EP_EVENT == 3'h0 |=> out_flag_reg == 4'h0)
    else $error("out flags not cleared by read");
  AST_HIGH_ZERO: assert property (O_AXI_RVALID |-> O_AXI_RDATA[31:4] == 28'h0)
    else $error("upper read bits not zero");
  AST_OUT_BIT0: assert property (out_flag_reg[0] == 1'b0 && out_mask_reg[0] == 1'b0)
    else $error("out bit 0 not zero");
  AST_SOF_SET: assert property (sof_set ##1 !clr_bus [*2] |-> bus_flag_reg[`UIFB_BIT_SOF])
    else $error("frame flag not set");
  AST_RST_SET: assert property (I_BUS_RESET_DET |=> bus_flag_reg[`UIFB_BIT_BUS_RESET])
    else $error("bus reset flag not set");
  AST_WAKE_ASLEEP: assert property ($rose(bus_flag_reg[`UIFB_BIT_WAKE]) |-> $past(sleep_state_reg))
    else $error("wake flag set while awake");
  AST_SLEEP_GATED: assert property ($rose(bus_flag_reg[`UIFB_BIT_SLEEP]) |-> $past(ctrl_reg[0]))
    else $error("sleep flag set while detection off");
  AST_BUS_CLEAR: assert property (clr_bus && bus_set == 4'h0 |=> bus_flag_reg == 4'h0)
    else $error("bus flags not cleared by read");
  AST_IRQ: assert property (ctrl_reg[`UIFB_CTRL_GIE] && any_pend |=> O_IRQ)
    else $error("interrupt not raised");
  AST_IRQ_GATED: assert property (!ctrl_reg[`UIFB_CTRL_GIE] |=> !O_IRQ)
    else $error("interrupt raised while disabled");
  AST_LEAVE_SLEEP: assert property (clr_bus && wake_seen_reg && !sleep_set |=> !O_SLEEP_STATE)
    else $error("suspend not left after resume read");
  AST_SET_WINS: assert property (clr_in && in_set != 4'h0 |=> (in_flag_reg & $past(in_set)) == $past(in_set))
    else $error("event lost against clearing read");

endmodule : uifb_top

// ---- dv/uifb_sie_model.sv ----
`timescale 1ns/100ps
// ****************************************************************
// serial engine stand-in: event pulses from the bus side
// ****************************************************************
module uifb_sie_model (
  input  wire logic i_clk,
  output logic [3:0] o_in_ep,
  output logic [3:1] o_out_ep,
  output logic       o_sof,
  output logic       o_bus_reset,
  output logic       o_resume,
  output logic       o_suspend
);
  // idle low between events, since a held level keeps setting flags
  initial begin
    {o_in_ep, o_out_ep, o_sof, o_bus_reset, o_resume, o_suspend} = 11'h000;
  end

  // call right after a rising edge; the pulse stands one cycle only
  // order {in[3:0], out[3:1], sof, bus reset, resume, suspend}
  task automatic fire(input logic [10:0] ev);
    {o_in_ep, o_out_ep, o_sof, o_bus_reset, o_resume, o_suspend} <= ev;
    @(posedge i_clk);
    {o_in_ep, o_out_ep, o_sof, o_bus_reset, o_resume, o_suspend} <= 11'h000;
  endtask : fire
endmodule : uifb_sie_model

// ---- dv/uifb_top_bench.sv ----
`timescale 1ns/100ps
`include "uifb_regs.svh"
module uifb_top_bench;
  // short frame so a missed token shows up quickly
  localparam int unsigned FRAME = 20;
  localparam logic [7:0]  RA [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
  localparam logic [3:0]  RV [9] = '{4'h0, 4'h0, 4'h0, `UIFB_RST_IN_MASK, `UIFB_RST_OUT_MASK,
                                     `UIFB_RST_BUS_MASK, 4'h0, 4'h0, 4'h0};
  localparam logic [10:0] EV [7] = '{11'h080, 11'h500, 11'h010, 11'h060, 11'h004, 11'h002, 11'h001};
  localparam logic [7:0]  EA [7] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08};
  localparam logic [3:0]  EX [7] = '{4'h1, 4'ha, 4'h2, 4'hc, 4'h4, 4'h0, 4'h0};

  logic        ref_clk;
  logic        reset_n;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        awvalid;
  logic        wvalid;
  logic        bready;
  logic        arvalid;
  logic        rready;
  wire logic   awready;
  wire logic   wready;
  wire logic   bvalid;
  wire logic   arready;
  wire logic   rvalid;
  wire logic   irq;
  wire logic   sleep_state;
  wire logic [1:0]  bresp;
  wire logic [1:0]  rresp;
  wire logic [31:0] rdata;
  wire logic [3:0]  in_ep;
  wire logic [3:1]  out_ep;
  wire logic   sof;
  wire logic   bus_rst;
  wire logic   resume;
  wire logic   suspend;
  int          miscompares;
  int          comparisons;
  logic [31:0] rd;
  logic [1:0]  rsp;

  uifb_top #(.FRAME_CYCLES(FRAME)) i_uifb_top (
    .I_REF_CLK(ref_clk), .I_RESET_N(reset_n),
    .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready),
    .I_AXI_WDATA(wdata), .I_AXI_WSTRB(wstrb), .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready),
    .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
    .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready),
    .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready),
    .I_IN_EP_EVENT(in_ep), .I_OUT_EP_EVENT(out_ep), .I_SOF_TOKEN(sof),
    .I_BUS_RESET_DET(bus_rst), .I_RESUME_DET(resume), .I_SUSPEND_DET(suspend),
    .O_IRQ(irq), .O_SLEEP_STATE(sleep_state)
  );

  uifb_sie_model i_uifb_sie_model (
    .i_clk(ref_clk), .o_in_ep(in_ep), .o_out_ep(out_ep), .o_sof(sof),
    .o_bus_reset(bus_rst), .o_resume(resume), .o_suspend(suspend)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  // address and data offered together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_left;
    logic w_left;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw_left = 1'b1;
    w_left = 1'b1;
    while (aw_left || w_left) begin
      @(posedge ref_clk);
      if (aw_left && awready === 1'b1) begin
        aw_left = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_left && wready === 1'b1) begin
        w_left = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  // ****************************************************************
  // clock, watchdog and test sequence
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // the whole run needs well under a thousand cycles
  initial begin
    tick(5000);
    miscompares++;
    close_out();
  end

  initial begin
    miscompares = 0;
    comparisons = 0;
    reset_n = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    tick(3);
    reset_n <= 1'b1;
    tick(1);
    // reset values, then an unmapped place answers with a decode error
    for (int i = 0; i < 9; i++) begin
      axi_rd(RA[i]);
      chk(rd, {28'h0, RV[i]}, "reset value");
      chk({30'h0, rsp}, (i == 8) ? 32'h3 : 32'h0, "read response");
    end
    chk({30'h0, irq, sleep_state}, 32'h0, "outputs after reset");
    $display("test reset done");
    // flag registers ignore writes; fixed zero bit of the out mask
    for (int i = 0; i < 3; i++) begin
      axi_wr(RA[i], 32'hffffffff);
      chk({30'h0, rsp}, 32'h0, "flag write response");
      axi_rd(RA[i]);
      chk(rd, 32'h0, "flag write ignored");
    end
    axi_wr(`UIFB_OFF_OUT_MASK, 32'hff);
    axi_rd(`UIFB_OFF_OUT_MASK);
    chk(rd, 32'he, "out mask bit0 fixed");
    axi_wr(8'h20, 32'h0);
    chk({30'h0, rsp}, 32'h3, "write decode error");
    // a write without the low byte lane is answered but changes nothing
    wstrb <= 4'he;
    axi_wr(`UIFB_OFF_BUS_MASK, 32'hf);
    wstrb <= 4'hf;
    axi_rd(`UIFB_OFF_BUS_MASK);
    chk(rd, {28'h0, `UIFB_RST_BUS_MASK}, "lane-less write ignored");
    $display("test writes done");
    // ordinary event rows: read shows the flags, a second read shows them cleared
    for (int i = 0; i < 7; i++) begin
      i_uifb_sie_model.fire(EV[i]);
      axi_rd(EA[i]);
      chk(rd, {28'h0, EX[i]}, "event flag");
      axi_rd(EA[i]);
      chk(rd, 32'h0, "cleared by read");
    end
    $display("test rows done");
    // interrupt raised, masked, unmasked and cleared
    axi_wr(`UIFB_OFF_CTRL, 32'h2);
    i_uifb_sie_model.fire(11'h080);
    tick(3);
    chk({31'h0, irq}, 32'h1, "irq raised");
    axi_wr(`UIFB_OFF_IN_MASK, 32'h0);
    tick(2);
    chk({31'h0, irq}, 32'h0, "irq masked");
    axi_wr(`UIFB_OFF_IN_MASK, 32'hf);
    tick(2);
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    axi_rd(`UIFB_OFF_IN_FLAGS);
    chk(rd, 32'h1, "irq source");
    tick(2);
    chk({31'h0, irq}, 32'h0, "irq cleared by read");
    $display("test irq done");
    // suspend with detection enabled, then resume while asleep
    axi_wr(`UIFB_OFF_CTRL, 32'h3);
    i_uifb_sie_model.fire(11'h001);
    axi_rd(`UIFB_OFF_BUS_FLAGS);
    chk(rd, 32'h1, "suspend flag");
    chk({31'h0, sleep_state}, 32'h1, "asleep");
    i_uifb_sie_model.fire(11'h002);
    axi_rd(`UIFB_OFF_BUS_FLAGS);
    chk(rd, 32'h2, "resume flag");
    tick(2);
    chk({31'h0, sleep_state}, 32'h0, "awake after read");
    $display("test sleep done");
    // event lands on the very edge that takes the clearing read
    fork
      i_uifb_sie_model.fire(11'h200);
      axi_rd(`UIFB_OFF_IN_FLAGS);
    join
    chk(rd, 32'h0, "old value on collision");
    axi_rd(`UIFB_OFF_IN_FLAGS);
    chk(rd, 32'h4, "event kept on collision");
    $display("test collision done");
    // real token, then a frame with the token missing
    i_uifb_sie_model.fire(11'h008);
    axi_rd(`UIFB_OFF_BUS_FLAGS);
    chk(rd, 32'h8, "frame token flag");
    tick(FRAME + 4);
    axi_rd(`UIFB_OFF_BUS_FLAGS);
    chk(rd, 32'h8, "synthesized frame flag");
    $display("test frame done");
    // reset in mid-run drops pending flags and disarms the frame timer
    i_uifb_sie_model.fire(11'h788);
    reset_n <= 1'b0;
    tick(3);
    reset_n <= 1'b1;
    tick(1);
    axi_rd(`UIFB_OFF_IN_FLAGS);
    chk(rd, 32'h0, "in flags after reset");
    axi_rd(`UIFB_OFF_CTRL);
    chk(rd, 32'h0, "control after reset");
    chk({30'h0, irq, sleep_state}, 32'h0, "outputs after mid-run reset");
    tick(FRAME + 4);
    axi_rd(`UIFB_OFF_BUS_FLAGS);
    chk(rd, 32'h0, "no frame before a token");
    $display("test midrun reset done");
    close_out();
  end
endmodule : uifb_top_bench
